// File: rtl/fmt_timer_bank.sv
// bank of independent four-mode function timers with a plain register port
// Functional notes
// - up to four independent timers, own mode each
// - type selector: off, pulse, delay, countdown, min-on
// - pulse mode: rising input sets output
// - pulse: output low once elapsed reaches duration
// - pulse: retrigger while high restarts elapsed
// - pulse: triggered flag follows output
// - delay: output low until input held long
// - delay: elapsed counts while high, zero low
// - delay: output high until input drops
// - delay: triggered flag follows input
// - countdown: nonzero duration write sets output
// - countdown: duration decrements, zero clears output
// - countdown: duration writable at any time
// - countdown: no reload after reaching zero
// - countdown: input gates count and output
// - countdown: triggered on write, cleared at end
// - min-on: rising input sets output
// - min-on: falling input starts timing to off
// - min-on: input back high clears elapsed
// - min-on: triggered while elapsed above zero
// - times span zero to 99:59:59, copied
//
// Added by the designer: the plain strobed port and the address map.
module fmt_timer_bank
    import fmt_pkg::*;
#(
    parameter int NT = N_TIMERS,
    parameter int TICKS = TICK_CYCLES
) (
    input wire logic clk,                   // 10 MHz system clock
    input wire logic reset_n,               // asynchronous reset, active low
    input wire logic [ADDR_W-1:0] addr,     // register byte address
    input wire logic [DATA_W-1:0] wdata,    // write data
    input wire logic wr_en,                 // write strobe
    input wire logic rd_en,                 // read strobe
    output logic [DATA_W-1:0] rdata,        // read data, cycle after rd_en
    input wire logic [NT-1:0] timer_in,     // trigger or gate inputs, asynchronous
    output logic [NT-1:0] timer_out,        // timer outputs
    output logic [NT-1:0] timer_trig        // timing indicators
);
    localparam int TCW = $clog2(TICKS + 1);

    // saturating increment keeps elapsed inside the printed range
    function automatic logic [TIME_W-1:0] tinc(input logic [TIME_W-1:0] v);
        tinc = (v >= TIME_MAX) ? TIME_MAX : v + TIME_ONE;
    endfunction

    function automatic logic [TIME_W-1:0] tclamp(input logic [DATA_W-1:0] v);
        tclamp = (v > DATA_W'(TIME_MAX)) ? TIME_MAX : v[TIME_W-1:0];
    endfunction

    function automatic fmt_mode_t decode_mode(input logic [2:0] c);
        case (c)
            CODE_PULSE: decode_mode = MODE_PULSE;
            CODE_DELAY: decode_mode = MODE_DELAY;
            CODE_ONESHOT: decode_mode = MODE_ONESHOT;
            CODE_MINON: decode_mode = MODE_MINON;
            default: decode_mode = MODE_OFF;
        endcase
    endfunction

    function automatic logic [2:0] encode_mode(input fmt_mode_t m);
        case (m)
            MODE_PULSE: encode_mode = CODE_PULSE;
            MODE_DELAY: encode_mode = CODE_DELAY;
            MODE_ONESHOT: encode_mode = CODE_ONESHOT;
            MODE_MINON: encode_mode = CODE_MINON;
            default: encode_mode = CODE_OFF;
        endcase
    endfunction

    // input synchronisers; in_meta is read only by in_s
    logic [NT-1:0] in_meta;
    logic [NT-1:0] in_s;
    logic [NT-1:0] in_d;

    // tenth-second time base
    logic [TCW-1:0] tick_cnt;
    logic [TCW-1:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    // per-timer state
    fmt_mode_t mode [NT];
    fmt_mode_t next_mode [NT];
    logic [TIME_W-1:0] dur [NT];
    logic [TIME_W-1:0] next_dur [NT];
    logic [TIME_W-1:0] elapsed [NT];
    logic [TIME_W-1:0] next_elapsed [NT];
    logic [TIME_W-1:0] limit [NT];
    logic [TIME_W-1:0] next_limit [NT];
    logic [NT-1:0] armed;
    logic [NT-1:0] next_armed;
    logic [NT-1:0] counting;
    logic [NT-1:0] next_counting;
    logic [NT-1:0] next_out;
    logic [NT-1:0] next_trig;
    logic [DATA_W-1:0] next_rdata;

    logic [IDX_W-1:0] acc_idx;
    logic [3:0] acc_reg;
    assign acc_idx = addr[IDX_LSB+IDX_W-1:IDX_LSB];
    assign acc_reg = addr[3:0];

    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + TCW'(1);
        if (tick_cnt >= TCW'(TICKS - 1)) begin
            next_tick_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_comb begin
        logic rise;
        logic fall;
        logic [TIME_W-1:0] lim;
        logic [TIME_W-1:0] inc;
        rise = 1'b0;
        fall = 1'b0;
        lim = TIME_ZERO;
        inc = TIME_ZERO;
        for (int i = 0; i < NT; i++) begin
            next_mode[i] = mode[i];
            next_dur[i] = dur[i];
            next_elapsed[i] = elapsed[i];
            next_limit[i] = limit[i];
            next_armed[i] = armed[i];
            next_counting[i] = counting[i];
            next_out[i] = timer_out[i];
            next_trig[i] = timer_trig[i];
            rise = in_s[i] & ~in_d[i];
            fall = ~in_s[i] & in_d[i];
            inc = tinc(elapsed[i]);
            case (mode[i])
                MODE_PULSE: begin
                    if (rise) begin
                        // start or retrigger: fresh copy of the duration
                        next_out[i] = 1'b1;
                        next_elapsed[i] = TIME_ZERO;
                        next_limit[i] = dur[i];
                    end else if (timer_out[i] && tick) begin
                        next_elapsed[i] = inc;
                        if (inc >= limit[i]) begin
                            next_out[i] = 1'b0;
                        end
                    end
                    next_trig[i] = next_out[i];
                end
                MODE_DELAY: begin
                    if (!in_s[i]) begin
                        next_elapsed[i] = TIME_ZERO;
                        next_out[i] = 1'b0;
                    end else begin
                        lim = rise ? dur[i] : limit[i];
                        if (rise) begin
                            next_limit[i] = dur[i];
                        end
                        if (tick && !rise && elapsed[i] < lim) begin
                            next_elapsed[i] = inc;
                        end
                        // once reached, stays high while input holds
                        next_out[i] = timer_out[i] | (next_elapsed[i] >= lim);
                    end
                    next_trig[i] = in_s[i];
                end
                MODE_ONESHOT: begin
                    next_elapsed[i] = TIME_ZERO;
                    // the duration itself runs down; nothing reloads it
                    if (tick && armed[i] && in_s[i] && dur[i] != TIME_ZERO) begin
                        next_dur[i] = dur[i] - TIME_ONE;
                    end
                    next_armed[i] = armed[i] && next_dur[i] != TIME_ZERO;
                    next_out[i] = next_armed[i] && in_s[i];
                    next_trig[i] = next_armed[i];
                end
                MODE_MINON: begin
                    if (rise) begin
                        next_out[i] = 1'b1;
                        next_elapsed[i] = TIME_ZERO;
                        next_counting[i] = 1'b0;
                    end else if (fall && timer_out[i]) begin
                        next_counting[i] = 1'b1;
                        next_limit[i] = dur[i];
                    end else if (counting[i] && tick) begin
                        if (inc >= limit[i]) begin
                            // done: clearing elapsed drops the indicator with the output
                            next_out[i] = 1'b0;
                            next_counting[i] = 1'b0;
                            next_elapsed[i] = TIME_ZERO;
                        end else begin
                            next_elapsed[i] = inc;
                        end
                    end
                    next_trig[i] = next_elapsed[i] != TIME_ZERO;
                end
                default: begin
                    next_elapsed[i] = TIME_ZERO;
                    next_out[i] = 1'b0;
                    next_trig[i] = 1'b0;
                    next_armed[i] = 1'b0;
                    next_counting[i] = 1'b0;
                end
            endcase
            // software writes win over the timing above in the same cycle
            if (wr_en && acc_idx == IDX_W'(i)) begin
                if (acc_reg == REG_TYPE) begin
                    next_mode[i] = decode_mode(wdata[2:0]);
                    next_elapsed[i] = TIME_ZERO;
                    next_out[i] = 1'b0;
                    next_trig[i] = 1'b0;
                    next_armed[i] = 1'b0;
                    next_counting[i] = 1'b0;
                end else if (acc_reg == REG_TIME) begin
                    next_dur[i] = tclamp(wdata);
                    if (mode[i] == MODE_ONESHOT) begin
                        next_armed[i] = tclamp(wdata) != TIME_ZERO;
                        next_out[i] = next_armed[i] && in_s[i];
                        next_trig[i] = next_armed[i];
                    end
                end
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        if (rd_en && acc_idx < IDX_W'(NT)) begin
            for (int i = 0; i < NT; i++) begin
                if (acc_idx == IDX_W'(i)) begin
                    case (acc_reg)
                        REG_TYPE: next_rdata = DATA_W'(encode_mode(mode[i]));
                        REG_TIME: next_rdata = DATA_W'(dur[i]);
                        REG_ELAPSED: next_rdata = DATA_W'(elapsed[i]);
                        REG_STATUS: begin
                            next_rdata[ST_OUT] = timer_out[i];
                            next_rdata[ST_TRIG] = timer_trig[i];
                            next_rdata[ST_INPUT] = in_s[i];
                            next_rdata[ST_COUNTING] = counting[i] | armed[i];
                        end
                        default: next_rdata = '0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_meta <= '0;
            in_s <= '0;
            in_d <= '0;
            tick_cnt <= '0;
            tick <= 1'b0;
            armed <= '0;
            counting <= '0;
            timer_out <= '0;
            timer_trig <= '0;
            rdata <= '0;
            for (int i = 0; i < NT; i++) begin
                mode[i] <= MODE_OFF;
                dur[i] <= TIME_ZERO;
                elapsed[i] <= TIME_ZERO;
                limit[i] <= TIME_ZERO;
            end
        end else begin
            in_meta <= timer_in;
            in_s <= in_meta;
            in_d <= in_s;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            armed <= next_armed;
            counting <= next_counting;
            timer_out <= next_out;
            timer_trig <= next_trig;
            rdata <= next_rdata;
            for (int i = 0; i < NT; i++) begin
                mode[i] <= next_mode[i];
                dur[i] <= next_dur[i];
                elapsed[i] <= next_elapsed[i];
                limit[i] <= next_limit[i];
            end
        end
    end

    // checks, one copy per timer, so every mode is watched wherever it runs
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    for (genvar g = 0; g < NT; g++) begin : g_chk
        logic wr_g;
        logic rise_g;
        logic fall_g;
        assign wr_g = wr_en && acc_idx == IDX_W'(g);
        assign rise_g = in_s[g] & ~in_d[g];
        assign fall_g = ~in_s[g] & in_d[g];

        sequence s_pulse_rise;
            mode[g] == MODE_PULSE && rise_g && !wr_g;
        endsequence

        sequence s_minon_rise;
            mode[g] == MODE_MINON && rise_g && !wr_g;
        endsequence

        sequence s_minon_fall;
            mode[g] == MODE_MINON && fall_g && timer_out[g] && !wr_g;
        endsequence

        property p_off_idle;
            mode[g] == MODE_OFF |-> !timer_out[g] && !timer_trig[g] && elapsed[g] == TIME_ZERO;
        endproperty
        a_off_idle: assert property (p_off_idle) else $error("off timer not idle");

        property p_pulse_start;
            s_pulse_rise |=> timer_out[g] && elapsed[g] == TIME_ZERO && limit[g] == $past(dur[g]);
        endproperty
        a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

        property p_pulse_trig;
            mode[g] == MODE_PULSE |-> timer_trig[g] == timer_out[g];
        endproperty
        a_pulse_trig: assert property (p_pulse_trig) else $error("pulse indicator differs from output");

        property p_pulse_end;
            mode[g] == MODE_PULSE && timer_out[g] && tick && !rise_g && !wr_g && tinc(elapsed[g]) >= limit[g]
                |=> !timer_out[g];
        endproperty
        a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end at duration");

        property p_delay_low;
            mode[g] == MODE_DELAY && !in_s[g] && !wr_g |=> !timer_out[g] && elapsed[g] == TIME_ZERO;
        endproperty
        a_delay_low: assert property (p_delay_low) else $error("delay output or elapsed not cleared");

        property p_delay_trig;
            mode[g] == MODE_DELAY && !wr_g |=> timer_trig[g] == $past(in_s[g]);
        endproperty
        a_delay_trig: assert property (p_delay_trig) else $error("delay indicator not following input");

        property p_delay_hold;
            mode[g] == MODE_DELAY && in_s[g] && !tick && !rise_g && !wr_g |=> elapsed[g] == $past(elapsed[g]);
        endproperty
        a_delay_hold: assert property (p_delay_hold) else $error("delay elapsed moved without tick");

        property p_oneshot_write;
            mode[g] == MODE_ONESHOT && wr_g && acc_reg == REG_TIME && wdata != '0
                |=> timer_trig[g] && armed[g] && timer_out[g] == $past(in_s[g]);
        endproperty
        a_oneshot_write: assert property (p_oneshot_write) else $error("countdown not started by write");

        property p_oneshot_gate;
            mode[g] == MODE_ONESHOT && !in_s[g] && !wr_g |=> !timer_out[g] && dur[g] == $past(dur[g]);
        endproperty
        a_oneshot_gate: assert property (p_oneshot_gate) else $error("countdown ran with gate low");

        property p_oneshot_stay;
            mode[g] == MODE_ONESHOT && dur[g] == TIME_ZERO && !wr_g |=> dur[g] == TIME_ZERO && !armed[g];
        endproperty
        a_oneshot_stay: assert property (p_oneshot_stay) else $error("countdown reloaded itself");

        property p_minon_rise;
            s_minon_rise |=> timer_out[g] && elapsed[g] == TIME_ZERO && !counting[g];
        endproperty
        a_minon_rise: assert property (p_minon_rise) else $error("min-on rise mishandled");

        property p_minon_fall;
            s_minon_fall |=> counting[g] && timer_out[g];
        endproperty
        a_minon_fall: assert property (p_minon_fall) else $error("min-on fall did not start timing");

        property p_minon_trig;
            mode[g] == MODE_MINON |-> timer_trig[g] == (elapsed[g] != TIME_ZERO);
        endproperty
        a_minon_trig: assert property (p_minon_trig) else $error("min-on indicator wrong");
    end

    property p_tick_spacing;
        tick |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick longer than one cycle");
endmodule

// File: rtl/fmt_pkg.sv
// constants, register map and mode type for the four-mode timer bank
package fmt_pkg;
    localparam int N_TIMERS = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TIME_W = 22;
    // 99:59:59 expressed in tenths of a second
    localparam logic [TIME_W-1:0] TIME_MAX = 22'h36EE76;
    localparam logic [TIME_W-1:0] TIME_ZERO = 22'h000000;
    localparam logic [TIME_W-1:0] TIME_ONE = 22'h000001;

    // timer index in addr[7:4], register in addr[3:0]
    localparam int IDX_LSB = 4;
    localparam int IDX_W = 4;
    localparam logic [3:0] REG_TYPE = 4'h0;
    localparam logic [3:0] REG_TIME = 4'h4;
    localparam logic [3:0] REG_ELAPSED = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // status register bit positions
    localparam int ST_OUT = 0;
    localparam int ST_TRIG = 1;
    localparam int ST_INPUT = 2;
    localparam int ST_COUNTING = 3;

    // software encoding of the type field
    localparam logic [2:0] CODE_OFF = 3'h0;
    localparam logic [2:0] CODE_PULSE = 3'h1;
    localparam logic [2:0] CODE_DELAY = 3'h2;
    localparam logic [2:0] CODE_ONESHOT = 3'h3;
    localparam logic [2:0] CODE_MINON = 3'h4;

    // time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 100000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_PULSE,
        MODE_DELAY,
        MODE_ONESHOT,
        MODE_MINON
    } fmt_mode_t;
endpackage

// File: verif/fmt_src_model.sv
// soft-wired digital sources that feed the timer inputs, with selectable lag
module fmt_src_model #(
    parameter int NT = 4
) (
    input wire logic clk,            // bench clock
    input wire logic [NT-1:0] lvl,   // levels requested by the bench
    input wire logic slow,           // high adds two cycles of wiring lag
    output logic [NT-1:0] pin        // wired trigger or gate inputs
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NT-1:0] d1 = '0;
    logic [NT-1:0] d2 = '0;
    logic [NT-1:0] d3 = '0;
    // a plain registered source; the lag shows the design copes with late wiring
    always_ff @(posedge clk) begin
        d1 <= lvl;
        d2 <= d1;
        d3 <= d2;
    end
    assign pin = slow ? d3 : d1;
endmodule

// File: verif/fmt_timer_bank_tb.sv
// self-checking bench for the four-mode timer bank
module fmt_timer_bank_tb
    import fmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // short tick keeps each tenth-second step to ten clocks
    localparam int T = 10;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h00000000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] lvl = 4'h0;
    logic slow = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [3:0] pin;
    logic [3:0] tout;
    logic [3:0] ttrig;
    int fails = 0;
    int tests_run = 0;
    int exp_type[4];
    int exp_time[4];
    int n;
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] v1;

    fmt_timer_bank #(.NT(4), .TICKS(T)) u_fmt_timer_bank (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .timer_in(pin), .timer_out(tout),
        .timer_trig(ttrig));
    fmt_src_model #(.NT(4)) u_fmt_src_model (.clk(clk), .lvl(lvl), .slow(slow), .pin(pin));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    function automatic logic [7:0] ad(input int i, input logic [3:0] r);
        return {4'(i), r};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd_get(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_get(a, d);
        chk(d, exp);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic set_in(input int i, input logic b, input int k);
        @(posedge clk);
        lvl[i] <= b;
        cyc(k);
    endtask

    task automatic wait_out(input int i, input logic b, output int k);
        k = 0;
        while (tout[i] !== b && k < 2000) begin
            @(posedge clk);
            #1 k++;
        end
    endtask

    initial begin
        #(20000 * 100);
        fails++;
        end_of_test();
    end

    initial begin
        void'($urandom(71486));
        cyc(16);
        reset_n = 1'b1;
        cyc(1);
        chk(tout, 4'h0);
        chk(ttrig, 4'h0);
        for (int i = 0; i < 4; i++) begin
            rd(ad(i, REG_TYPE), 32'h0);
            rd(ad(i, REG_TIME), 32'h0);
        end
        rd(8'h40, 32'h0);
        rd(ad(0, 4'h2), 32'h0);
        // every type code on every timer, read back from the timer bank and checked against the expected type
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 4; i++) begin
                wr(ad(i, REG_TYPE), 32'((c + i) % 8));
                exp_type[i] = ((c + i) % 8) > 4 ? 0 : (c + i) % 8;
            end
            for (int i = 0; i < 4; i++) rd(ad(i, REG_TYPE), 32'(exp_type[i]));
        end
        for (int i = 0; i < 4; i++) wr(ad(i, REG_TYPE), 32'(CODE_OFF));
        // random time values clamp at the top of the range; random toggles on off timers
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 32'hFFFFFFFF : $urandom;
            if (k > 6) v = v % 32'h00400000;
            exp_time[k % 4] = (v > 32'(TIME_MAX)) ? int'(TIME_MAX) : int'(v);
            wr(ad(k % 4, REG_TIME), v);
            rd(ad(k % 4, REG_TIME), 32'(exp_time[k % 4]));
            set_in(k % 4, 1'($urandom % 2), 4);
            chk(tout, 4'h0);
            chk(ttrig, 4'h0);
            rd(ad(k % 4, REG_ELAPSED), 32'h0);
        end
        wr(ad(0, REG_ELAPSED), 32'h5);
        rd(ad(0, REG_ELAPSED), 32'h0);
        lvl <= 4'h0;
        cyc(6);
        // fixed pulse, duration 3, retriggered mid-pulse
        wr(ad(0, REG_TIME), 32'h3);
        wr(ad(0, REG_TYPE), 32'(CODE_PULSE));
        set_in(0, 1'b1, 5);
        chk(tout[0], 1'b1);
        chk(ttrig[0], 1'b1);
        // retrigger well before the first pulse could end at any tick phase
        cyc(2);
        set_in(0, 1'b0, 3);
        set_in(0, 1'b1, 0);
        wait_out(0, 1'b0, n);
        chk_rng(n, 2 * T + 5, 3 * T + 6);
        chk(ttrig[0], 1'b0);
        rd(ad(0, REG_ELAPSED), 32'h3);
        // on delay, duration 4
        wr(ad(1, REG_TIME), 32'h4);
        wr(ad(1, REG_TYPE), 32'(CODE_DELAY));
        set_in(1, 1'b1, 5);
        chk(ttrig[1], 1'b1);
        chk(tout[1], 1'b0);
        wait_out(1, 1'b1, n);
        chk_rng(n + 5, 3 * T, 4 * T + 6);
        cyc(25);
        chk(tout[1], 1'b1);
        rd(ad(1, REG_ELAPSED), 32'h4);
        rd(ad(1, REG_STATUS), 32'h7);
        set_in(1, 1'b0, 5);
        chk(tout[1], 1'b0);
        chk(ttrig[1], 1'b0);
        rd(ad(1, REG_ELAPSED), 32'h0);
        // single countdown gated by its input
        wr(ad(2, REG_TYPE), 32'(CODE_ONESHOT));
        set_in(2, 1'b1, 5);
        chk(tout[2], 1'b0);
        wr(ad(2, REG_TIME), 32'h5);
        cyc(2);
        chk(tout[2], 1'b1);
        chk(ttrig[2], 1'b1);
        cyc(12);
        set_in(2, 1'b0, 5);
        chk(tout[2], 1'b0);
        chk(ttrig[2], 1'b1);
        rd(ad(2, REG_STATUS), 32'hA);
        rd_get(ad(2, REG_TIME), v1);
        chk_rng(int'(v1), 3, 4);
        cyc(3 * T);
        rd(ad(2, REG_TIME), v1);
        set_in(2, 1'b1, 5);
        chk(tout[2], 1'b1);
        wr(ad(2, REG_TIME), 32'h2);
        wait_out(2, 1'b0, n);
        chk_rng(n, T - 2, 2 * T + 4);
        chk(ttrig[2], 1'b0);
        cyc(4 * T);
        chk(tout[2], 1'b0);
        rd(ad(2, REG_TIME), 32'h0);
        // minimum on, duration 3, slow wiring
        slow <= 1'b1;
        wr(ad(3, REG_TIME), 32'h3);
        wr(ad(3, REG_TYPE), 32'(CODE_MINON));
        set_in(3, 1'b1, 7);
        chk(tout[3], 1'b1);
        chk(ttrig[3], 1'b0);
        rd(ad(3, REG_STATUS), 32'h5);
        set_in(3, 1'b0, 2 * T);
        chk(tout[3], 1'b1);
        chk(ttrig[3], 1'b1);
        set_in(3, 1'b1, 7);
        rd(ad(3, REG_ELAPSED), 32'h0);
        chk(ttrig[3], 1'b0);
        cyc(3 * T);
        chk(tout[3], 1'b1);
        set_in(3, 1'b0, 0);
        wait_out(3, 1'b0, n);
        chk_rng(n, 2 * T, 3 * T + 8);
        chk(ttrig[3], 1'b0);
        rd(ad(3, REG_ELAPSED), 32'h0);
        chk(tout, 4'h0);
        // reset in mid-run clears everything
        set_in(0, 1'b1, 5);
        reset_n = 1'b0;
        cyc(2);
        chk(tout, 4'h0);
        reset_n = 1'b1;
        rd(ad(0, REG_TYPE), 32'h0);
        end_of_test();
    end
endmodule
